// >>> core/csp_interp.sv
`timescale 1ns/1ps
`include "csp_regs.svh"
module csp_interp import csp_pkg::*; #(
	parameter int LOOP_CYC = `CSP_LOOP_PERIOD_NS / `CSP_CLK_PERIOD_NS,
	parameter int NW       = 10
) (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        arst_n_in,
	// Object dictionary access
	input  wire csp_od_req_t od_req_in,
	output csp_od_rsp_t      od_rsp_out,
	// Drive and network status
	input  wire logic        csp_mode_in,
	input  wire logic        sync_in,
	input  wire logic [15:0] torque_in,
	output logic       [7:0] network_state_indicator_out,
	output logic             period_err_out,
	output logic             loop_tick_out,
	output logic             profile_start_out,
	// Homing settings
	output logic      [31:0] homing_switch_speed_out,
	output logic      [31:0] homing_zero_speed_out,
	output logic      [31:0] homing_accel_out,
	output logic      [31:0] homing_decel_out,
	// Position command stream
	output csp_cmd_t         cmd_out,
	output logic             cmd_valid_out,
	input  wire logic        cmd_ready_in
);
	// Object storage
	logic [15:0]        torque_q;
	logic signed [31:0] target_q;
	logic [31:0]        ramp_q;
	logic signed [31:0] bias_q;
	logic [7:0]         per_val_q;
	logic [7:0]         per_idx_q;
	logic [NW-1:0]      per_n_q;
	logic               dc_en_q;
	// Timing
	logic [31:0]        loop_cnt_q;
	logic [NW-1:0]      lp_cnt_q;
	logic               loop_tick;
	logic               prof_start;
	// Interpolation
	logic signed [31:0] last_q;
	logic signed [31:0] pos_q;
	logic               neg_q;
	logic [31:0]        step_q;
	logic [NW-1:0]      frac_q;
	logic [NW-1:0]      acc_q;
	logic [31:0]        div_quo;
	logic [NW-1:0]      div_rem;
	logic               div_done;
	logic [31:0]        delta_mag;
	logic signed [31:0] delta;
	logic [NW:0]        acc_sum;
	logic               carry;
	logic [31:0]        step_mag;
	logic signed [31:0] step_signed;
	// Command handoff
	logic               emit_q;
	logic               pend_q;
	csp_cmd_t           pend_cmd_q;
	logic               buf_ready;
	logic [63:0]        buf_data;
	// Period check and object read decode
	logic [7:0]         chk_val;
	logic [7:0]         chk_idx;
	logic [19:0]        scale;
	logic [19:0]        per_us;
	logic               per_ok;
	logic               od_hit;
	logic               od_ro;
	logic [31:0]        od_rd;

	// Interpolation period check, applied to the value about to be written
	always_comb begin
		chk_val = per_val_q;
		chk_idx = per_idx_q;
		if (od_req_in.index == `CSP_OD_INTERP && od_req_in.sub == `CSP_SUB_FIRST) begin
			chk_val = od_req_in.data[7:0];
		end
		if (od_req_in.index == `CSP_OD_INTERP && od_req_in.sub == `CSP_SUB_SECOND) begin
			chk_idx = od_req_in.data[7:0];
		end
		unique case (chk_idx)
			8'hfa:   scale = 20'h00001;
			8'hfb:   scale = 20'h0000a;
			8'hfc:   scale = 20'h00064;
			8'hfd:   scale = 20'h003e8;
			default: scale = 20'h00000;
		endcase
		per_us = 20'(chk_val * scale);
		// Coarser exponents would overflow the loop count, so they are refused too
		per_ok = (per_us != 20'h0) && (per_us % 20'(`CSP_LOOP_PERIOD_US) == 20'h0);
	end

	// Read decode and read-only marking
	always_comb begin
		od_hit = 1'b1;
		od_ro  = 1'b0;
		od_rd  = 32'h0;
		unique case (od_req_in.index)
			`CSP_OD_TORQUE: begin
				od_ro = 1'b1;
				od_rd = {{16{torque_q[15]}}, torque_q};
			end
			`CSP_OD_TARGET:     od_rd = target_q;
			`CSP_OD_HOME_RAMP:  od_rd = ramp_q;
			`CSP_OD_SPEED_BIAS: od_rd = bias_q;
			`CSP_OD_HOME_SPEED: begin
				if (od_req_in.sub == `CSP_SUB_COUNT) begin
					od_ro = 1'b1;
					od_rd = `CSP_ENTRY_COUNT;
				end else if (od_req_in.sub == `CSP_SUB_FIRST) begin
					od_rd = homing_switch_speed_out;
				end else if (od_req_in.sub == `CSP_SUB_SECOND) begin
					od_rd = homing_zero_speed_out;
				end else begin
					od_hit = 1'b0;
				end
			end
			`CSP_OD_INTERP: begin
				if (od_req_in.sub == `CSP_SUB_COUNT) begin
					od_ro = 1'b1;
					od_rd = `CSP_ENTRY_COUNT;
				end else if (od_req_in.sub == `CSP_SUB_FIRST) begin
					od_rd = {24'h0, per_val_q};
				end else if (od_req_in.sub == `CSP_SUB_SECOND) begin
					od_rd = {{24{per_idx_q[7]}}, per_idx_q};
				end else begin
					od_hit = 1'b0;
				end
			end
			`CSP_OD_SYNC_CTRL: od_rd = {30'h0, period_err_out, dc_en_q};
			default:           od_hit = 1'b0;
		endcase
	end

	// Object writes and answers
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			od_rsp_out              <= '0;
			target_q                <= '0;
			ramp_q                  <= '0;
			bias_q                  <= '0;
			homing_switch_speed_out <= '0;
			homing_zero_speed_out   <= '0;
			per_val_q               <= `CSP_PERIOD_VAL_RST;
			per_idx_q               <= `CSP_PERIOD_IDX_RST;
			per_n_q                 <= `CSP_PERIOD_N_RST;
			dc_en_q                 <= 1'b0;
			period_err_out          <= 1'b0;
		end else begin
			od_rsp_out.ack  <= od_req_in.valid;
			od_rsp_out.err  <= 1'b0;
			od_rsp_out.data <= od_req_in.valid && !od_req_in.wr ? od_rd : 32'h0;
			if (od_req_in.valid && (!od_hit || (od_req_in.wr && od_ro))) begin
				od_rsp_out.err <= 1'b1;
			end else if (od_req_in.valid && od_req_in.wr) begin
				unique case (od_req_in.index)
					`CSP_OD_TARGET:     target_q <= od_req_in.data;
					`CSP_OD_HOME_RAMP:  ramp_q   <= od_req_in.data;
					`CSP_OD_SPEED_BIAS: bias_q   <= od_req_in.data;
					`CSP_OD_HOME_SPEED: begin
						if (od_req_in.sub == `CSP_SUB_FIRST) begin
							homing_switch_speed_out <= od_req_in.data;
						end else begin
							homing_zero_speed_out <= od_req_in.data;
						end
					end
					`CSP_OD_INTERP: begin
						if (per_ok) begin
							per_val_q      <= chk_val;
							per_idx_q      <= chk_idx;
							per_n_q        <= NW'(per_us / 20'(`CSP_LOOP_PERIOD_US));
							period_err_out <= 1'b0;
						end else begin
							od_rsp_out.err <= 1'b1;
							period_err_out <= 1'b1;
						end
					end
					`CSP_OD_SYNC_CTRL: dc_en_q <= od_req_in.data[`CSP_SYNC_DC_BIT];
					default:           od_rsp_out.err <= 1'b1;
				endcase
			end
		end
	end

	assign homing_accel_out = ramp_q;
	assign homing_decel_out = ramp_q;

	// Network state drops to safe-operational when positioning runs unsynchronised
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			network_state_indicator_out <= `CSP_NSI_OP;
		end else begin
			network_state_indicator_out <= (csp_mode_in && !dc_en_q) ? `CSP_NSI_SAFEOP :
			                               `CSP_NSI_OP;
		end
	end

	// Loop tick: free 250 us, realigned by each network sync pulse while distributed clocks are enabled
	assign loop_tick  = (loop_cnt_q == 32'(LOOP_CYC - 1)) || (dc_en_q && sync_in);
	assign prof_start = dc_en_q ? sync_in : (loop_tick && lp_cnt_q == per_n_q - 1'b1);

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			loop_cnt_q        <= '0;
			lp_cnt_q          <= '0;
			loop_tick_out     <= 1'b0;
			profile_start_out <= 1'b0;
			torque_q          <= '0;
		end else begin
			loop_cnt_q        <= loop_tick ? 32'h0 : loop_cnt_q + 32'h1;
			loop_tick_out     <= loop_tick;
			profile_start_out <= prof_start;
			if (prof_start) begin
				lp_cnt_q <= '0;
			end else if (loop_tick && lp_cnt_q != '1) begin
				lp_cnt_q <= lp_cnt_q + 1'b1;
			end
			if (loop_tick) begin
				torque_q <= torque_in;
			end
		end
	end

	// Two-point set and linear stepping
	assign delta     = target_q - last_q;
	assign delta_mag = delta[31] ? 32'(-delta) : 32'(delta);
	assign acc_sum   = {1'b0, acc_q} + {1'b0, frac_q};
	assign carry     = acc_sum >= {1'b0, per_n_q};
	assign step_mag  = step_q + {31'h0, carry};
	assign step_signed = neg_q ? -$signed(step_mag) : $signed(step_mag);

	csp_step_div #(
		.DW (32),
		.VW (NW)
	) u_div (
		.core_clk_in (core_clk_in),
		.arst_n_in   (arst_n_in),
		.start_in    (prof_start),
		.dividend_in (delta_mag),
		.divisor_in  (per_n_q),
		.quo_out     (div_quo),
		.rem_out     (div_rem),
		.done_out    (div_done)
	);

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			last_q <= '0;
			pos_q  <= '0;
			neg_q  <= 1'b0;
			step_q <= '0;
			frac_q <= '0;
			acc_q  <= '0;
		end else if (prof_start) begin
			last_q <= target_q;
			pos_q  <= last_q;
			neg_q  <= delta[31];
			step_q <= '0;
			frac_q <= '0;
			acc_q  <= '0;
		end else begin
			if (div_done) begin
				step_q <= div_quo;
				frac_q <= div_rem;
			end
			// Stop after the segment end so a late sync never overshoots
			if (loop_tick && lp_cnt_q < per_n_q) begin
				pos_q <= pos_q + step_signed;
				acc_q <= carry ? NW'(acc_sum - {1'b0, per_n_q}) : NW'(acc_sum);
			end
		end
	end

	// Command emitted the cycle after each tick in cyclic position mode; a stalled slot keeps the newest
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			emit_q     <= 1'b0;
			pend_q     <= 1'b0;
			pend_cmd_q <= '0;
		end else begin
			emit_q <= loop_tick && csp_mode_in;
			if (emit_q) begin
				pend_q            <= 1'b1;
				pend_cmd_q.pos    <= pos_q;
				pend_cmd_q.vel_ff <= bias_q + $signed(neg_q ? -$signed(step_q) : step_q);
			end else if (buf_ready) begin
				pend_q <= 1'b0;
			end
		end
	end

	csp_cmd_buf #(
		.W     (64),
		.DEPTH (2)
	) u_buf (
		.core_clk_in   (core_clk_in),
		.arst_n_in     (arst_n_in),
		.in_valid_in   (pend_q),
		.in_data_in    (pend_cmd_q),
		.in_ready_out  (buf_ready),
		.out_valid_out (cmd_valid_out),
		.out_data_out  (buf_data),
		.out_ready_in  (cmd_ready_in)
	);

	assign cmd_out = buf_data;
endmodule

// >>> core/csp_regs.svh
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH
// Summary of operation
// - Homing uses one 32-bit ramp value for both acceleration and deceleration, default 0.
// - Positioning without distributed clocks drops the network indicator to value 4.
// - Linear interpolation between commands delays the position by exactly one command.
// - Interpolation period must be a whole multiple of the loop time; checked.
// - Period exponent index accepted down to -6, one microsecond resolution.
// - Each interpolation period samples the commanded position once into the point set.
// - New point discards the oldest; exactly two points kept for linear steps.
// - A velocity feed-forward is formed and applied during cyclic position mode.
// - Feed-forward input is the signed 32-bit speed bias object, default 0.
// - Motor torque is reported read-only in tenths of a percent, default 0.
// - Master writes signed 32-bit commanded position; drive moves toward it.
// - Loops align to the network time base under distributed clocks.
// - Position controller runs in step with the synchronized speed task.
// - A fresh drive position command is derived every 250 us.
// - Without distributed clocks the position loop runs on a fixed 250 us period.

// Object indices and sub-indices
`define CSP_OD_TORQUE       16'h6077
`define CSP_OD_TARGET       16'h607a
`define CSP_OD_HOME_SPEED   16'h6099
`define CSP_OD_HOME_RAMP    16'h609a
`define CSP_OD_SPEED_BIAS   16'h60b1
`define CSP_OD_INTERP       16'h60c2
`define CSP_OD_SYNC_CTRL    16'h2900
`define CSP_SUB_COUNT       8'h00
`define CSP_SUB_FIRST       8'h01
`define CSP_SUB_SECOND      8'h02
`define CSP_ENTRY_COUNT     32'h0000_0002

// Sync control fields
`define CSP_SYNC_DC_BIT     0
`define CSP_SYNC_ERR_BIT    1

// Reset values and period index range
`define CSP_PERIOD_VAL_RST  8'h01
`define CSP_PERIOD_IDX_RST  8'hfd
`define CSP_PERIOD_N_RST    10'h004
`define CSP_PERIOD_IDX_MIN  8'hfa
`define CSP_PERIOD_IDX_MAX  8'hfd

// Network indicator values
`define CSP_NSI_SAFEOP      8'h04
`define CSP_NSI_OP          8'h08

// Timing
`define CSP_CLK_PERIOD_NS   50
`define CSP_LOOP_PERIOD_NS  250000
`define CSP_LOOP_PERIOD_US  250
`endif

// >>> core/csp_pkg.sv
package csp_pkg;
	typedef struct packed {
		logic        valid;
		logic        wr;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] data;
	} csp_od_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [31:0] data;
	} csp_od_rsp_t;

	typedef struct packed {
		logic signed [31:0] pos;
		logic signed [31:0] vel_ff;
	} csp_cmd_t;

	typedef enum logic [1:0] {
		CSP_DIV_IDLE = 2'b00,
		CSP_DIV_RUN  = 2'b01,
		CSP_DIV_FIN  = 2'b11
	} csp_div_state_t;
endpackage

// >>> core/csp_step_div.sv
`timescale 1ns/1ps
module csp_step_div import csp_pkg::*; #(
	parameter int DW = 32,
	parameter int VW = 10
) (
	// Clock and reset
	input  wire logic          core_clk_in,
	input  wire logic          arst_n_in,
	// Request
	input  wire logic          start_in,
	input  wire logic [DW-1:0] dividend_in,
	input  wire logic [VW-1:0] divisor_in,
	// Result
	output logic      [DW-1:0] quo_out,
	output logic      [VW-1:0] rem_out,
	output logic               done_out
);
	csp_div_state_t    state_q;
	logic [DW-1:0]     num_q;
	logic [VW-1:0]     rem_q;
	logic [VW-1:0]     div_q;
	logic [5:0]        cnt_q;
	logic [VW:0]       trial;

	assign trial    = {rem_q, num_q[DW-1]};
	assign quo_out  = num_q;
	assign rem_out  = rem_q;

	// Serial restoring divide; one quotient bit per clock is ample within a loop period
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q  <= CSP_DIV_IDLE;
			num_q    <= '0;
			rem_q    <= '0;
			div_q    <= '0;
			cnt_q    <= '0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			unique case (state_q)
				CSP_DIV_IDLE: begin
					if (start_in) begin
						num_q   <= dividend_in;
						div_q   <= divisor_in;
						rem_q   <= '0;
						cnt_q   <= '0;
						state_q <= CSP_DIV_RUN;
					end
				end
				CSP_DIV_RUN: begin
					if (trial >= {1'b0, div_q}) begin
						rem_q <= VW'(trial - {1'b0, div_q});
						num_q <= {num_q[DW-2:0], 1'b1};
					end else begin
						rem_q <= trial[VW-1:0];
						num_q <= {num_q[DW-2:0], 1'b0};
					end
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == 6'(DW - 1)) begin
						state_q <= CSP_DIV_FIN;
					end
				end
				CSP_DIV_FIN: begin
					done_out <= 1'b1;
					state_q  <= CSP_DIV_IDLE;
				end
				default: state_q <= CSP_DIV_IDLE;
			endcase
		end
	end
endmodule

// >>> core/csp_cmd_buf.sv
`timescale 1ns/1ps
module csp_cmd_buf import csp_pkg::*; #(
	parameter int W     = 64,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic         core_clk_in,
	input  wire logic         arst_n_in,
	// Fill side
	input  wire logic         in_valid_in,
	input  wire logic [W-1:0] in_data_in,
	output logic              in_ready_out,
	// Drain side
	output logic              out_valid_out,
	output logic      [W-1:0] out_data_out,
	input  wire logic         out_ready_in
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0]   count_q;
	logic          push;
	logic          pop;
	logic [AW:0]   count_d;
	logic [AW-1:0] rd_ptr_d;
	logic [W-1:0]  head_d;

	assign push         = in_valid_in && in_ready_out;
	assign pop          = out_valid_out && out_ready_in;
	assign count_d      = push && !pop ? count_q + 1'b1 :
	                      (!push && pop ? count_q - 1'b1 : count_q);
	assign rd_ptr_d     = !pop ? rd_ptr_q :
	                      ((rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1);
	// Head held in a flop; a word landing in the head slot bypasses the array
	assign head_d       = (push && wr_ptr_q == rd_ptr_d) ? in_data_in : mem_q[rd_ptr_d];

	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
	end

	// Full and empty kept as flops so the ports see no decode glitches
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_ptr_q      <= '0;
			rd_ptr_q      <= '0;
			count_q       <= '0;
			in_ready_out  <= 1'b1;
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			rd_ptr_q      <= rd_ptr_d;
			out_data_out  <= head_d;
			count_q       <= count_d;
			in_ready_out  <= count_d != (AW + 1)'(DEPTH);
			out_valid_out <= count_d != '0;
		end
	end
endmodule

// >>> tb/csp_interp_checker.sv
`timescale 1ns/1ps
`include "csp_regs.svh"
module csp_interp_checker import csp_pkg::*; #(
	parameter int LOOP_CYC = 5000
) (
	// Clock and reset
	input wire logic        core_clk_in,
	input wire logic        arst_n_in,
	// Watched ports
	input wire csp_od_req_t od_req_in,
	input wire csp_od_rsp_t od_rsp_out,
	input wire logic        csp_mode_in,
	input wire logic        sync_in,
	input wire logic [7:0]  network_state_indicator_out,
	input wire logic        period_err_out,
	input wire logic        loop_tick_out,
	input wire logic        profile_start_out,
	input wire logic [31:0] homing_accel_out,
	input wire logic [31:0] homing_decel_out,
	input wire csp_cmd_t    cmd_out,
	input wire logic        cmd_valid_out,
	input wire logic        cmd_ready_in
);
	logic dc_q;
	logic seen_q;
	logic dcs_q;
	int   gap_q;
	logic wr_go;
	assign wr_go = od_req_in.valid && od_req_in.wr;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	// Sync control writes are never refused, so track them at the request
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			dc_q <= 1'b0;
		else if (wr_go && od_req_in.index == `CSP_OD_SYNC_CTRL)
			dc_q <= od_req_in.data[`CSP_SYNC_DC_BIT];
	end
	// Gap since last tick; a sync in that span may shorten it
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			gap_q  <= 0;
			seen_q <= 1'b0;
			dcs_q  <= 1'b0;
		end else begin
			gap_q  <= loop_tick_out ? 1 : gap_q + 1;
			seen_q <= seen_q | loop_tick_out;
			dcs_q  <= loop_tick_out ? dc_q : (dcs_q | dc_q);
		end
	end
	AST_ACK_NEXT: assert property (od_req_in.valid |=> od_rsp_out.ack)
		else $error("object access not answered next cycle");
	AST_ACK_CAUSE: assert property (od_rsp_out.ack |-> $past(od_req_in.valid))
		else $error("answer without an access");
	AST_RAMP_BOTH: assert property (homing_accel_out == homing_decel_out)
		else $error("homing ramp differs between speed-up and slow-down");
	AST_RAMP_LOAD: assert property (wr_go && od_req_in.index == `CSP_OD_HOME_RAMP
		|-> ##2 homing_accel_out == $past(od_req_in.data, 2)) else $error("ramp not loaded");
	AST_NSI_SAFEOP: assert property ((csp_mode_in && !dc_q)[*3]
		|-> network_state_indicator_out == `CSP_NSI_SAFEOP) else $error("indicator not 4");
	AST_NSI_OP: assert property ((!csp_mode_in || dc_q)[*3]
		|-> network_state_indicator_out == `CSP_NSI_OP) else $error("indicator not 8");
	AST_RO_REFUSE: assert property (wr_go && od_req_in.index == `CSP_OD_TORQUE
		|=> od_rsp_out.err) else $error("torque write accepted");
	AST_IDX_MIN: assert property (wr_go && od_req_in.index == `CSP_OD_INTERP
		&& od_req_in.sub == 8'h02 && od_req_in.data[7:0] inside {[8'h80:8'hf9]}
		|=> od_rsp_out.err) else $error("period index below range accepted");
	AST_PERIOD_FLAG: assert property (wr_go && od_req_in.index == `CSP_OD_INTERP
		&& od_req_in.sub inside {8'h01, 8'h02} ##1 1'b1
		|=> period_err_out == $past(od_rsp_out.err)) else $error("period flag wrong");
	AST_LOOP_GAP: assert property (loop_tick_out && seen_q && !dcs_q && !dc_q
		|-> gap_q == LOOP_CYC) else $error("free loop tick spacing wrong");
	AST_LOOP_DUE: assert property (seen_q && !dcs_q && !dc_q && gap_q == LOOP_CYC
		|-> loop_tick_out) else $error("free loop tick missing");
	AST_SYNC_PROFILE: assert property (sync_in && dc_q
		|-> ##[1:4] profile_start_out) else $error("sync did not start a profile");
	AST_STALL_HOLD: assert property (cmd_valid_out && !cmd_ready_in
		|=> cmd_valid_out && $stable(cmd_out)) else $error("command changed while stalled");
	COV_REFUSED: cover property (od_rsp_out.err);
	COV_STALL: cover property ((cmd_valid_out && !cmd_ready_in)[*4]);
	COV_SYNC: cover property (sync_in && dc_q ##[1:4] profile_start_out);
endmodule

bind csp_interp csp_interp_checker #(.LOOP_CYC(LOOP_CYC)) u_chk (
	.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .od_req_in(od_req_in),
	.od_rsp_out(od_rsp_out), .csp_mode_in(csp_mode_in), .sync_in(sync_in),
	.network_state_indicator_out(network_state_indicator_out),
	.period_err_out(period_err_out), .loop_tick_out(loop_tick_out),
	.profile_start_out(profile_start_out), .homing_accel_out(homing_accel_out),
	.homing_decel_out(homing_decel_out), .cmd_out(cmd_out),
	.cmd_valid_out(cmd_valid_out), .cmd_ready_in(cmd_ready_in)
);

// >>> tb/csp_master_model.sv
`timescale 1ns/1ps
module csp_master_model import csp_pkg::*; #(
	parameter int SYNC_CYC = 100
) (
	// Clock and reset
	input  wire logic     core_clk_in,
	input  wire logic     arst_n_in,
	// Bench controls
	input  wire logic     stall_in,
	input  wire logic     sync_en_in,
	// Drive side
	output logic          sync_out,
	output logic          cmd_ready_out,
	input  wire csp_cmd_t cmd_in,
	input  wire logic     cmd_valid_in
);
	csp_cmd_t got_q[$];
	int       cnt;
	initial begin
		sync_out = 1'b0;
		cmd_ready_out = 1'b1;
		cnt = 0;
	end
	always @(posedge core_clk_in)
		if (arst_n_in && cmd_valid_in && cmd_ready_out)
			got_q.push_back(cmd_in);
	// Pulses only once the bench has enabled distributed clocks
	always @(negedge core_clk_in) begin
		cmd_ready_out <= !stall_in;
		cnt <= sync_en_in ? (cnt + 1) % SYNC_CYC : 0;
		sync_out <= sync_en_in && cnt == SYNC_CYC - 1;
	end
endmodule

// >>> tb/csp_interp_tb.sv
`timescale 1ns/1ps
`include "csp_regs.svh"
module csp_interp_tb import csp_pkg::*;;
	localparam int LOOP = 50;
	logic        clk;
	logic        rst_n;
	csp_od_req_t req;
	csp_od_rsp_t rsp;
	logic        mode;
	logic        sync;
	logic [15:0] torque;
	logic [7:0]  nsi;
	logic        perr;
	logic [31:0] hsw;
	logic [31:0] hzero;
	logic [31:0] hacc;
	logic [31:0] hdec;
	csp_cmd_t    cmd;
	logic        cvalid;
	logic        ready;
	logic        stall;
	logic        sync_en;
	int          bad_count;
	int          checks_done;
	csp_interp #(.LOOP_CYC(LOOP), .NW(10)) u_dut (
		.core_clk_in(clk), .arst_n_in(rst_n), .od_req_in(req), .od_rsp_out(rsp),
		.csp_mode_in(mode), .sync_in(sync), .torque_in(torque),
		.network_state_indicator_out(nsi), .period_err_out(perr), .loop_tick_out(),
		.profile_start_out(), .homing_switch_speed_out(hsw), .homing_zero_speed_out(hzero),
		.homing_accel_out(hacc), .homing_decel_out(hdec), .cmd_out(cmd),
		.cmd_valid_out(cvalid), .cmd_ready_in(ready)
	);
	csp_master_model #(.SYNC_CYC(2 * LOOP)) u_master (
		.core_clk_in(clk), .arst_n_in(rst_n), .stall_in(stall), .sync_en_in(sync_en),
		.sync_out(sync), .cmd_ready_out(ready), .cmd_in(cmd), .cmd_valid_in(cvalid)
	);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic od_go(input logic w, input logic [15:0] i, input logic [7:0] s,
			input logic [31:0] d, output logic e, output logic [31:0] q);
		@(negedge clk);
		req = '{valid: 1'b1, wr: w, index: i, sub: s, data: d};
		@(negedge clk);
		// Released fields must not look like a live request
		req = '{valid: 1'b0, wr: ~w, index: ~i, sub: ~s, data: ~d};
		chk({31'h0, rsp.ack}, 32'h1);
		e = rsp.err;
		q = rsp.data;
	endtask
	task automatic wr_chk(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
			input logic e_exp);
		logic        e;
		logic [31:0] q;
		od_go(1'b1, i, s, d, e, q);
		chk({31'h0, e}, {31'h0, e_exp});
	endtask
	task automatic rd_chk(input logic [15:0] i, input logic [7:0] s, input logic [31:0] exp);
		logic        e;
		logic [31:0] q;
		od_go(1'b0, i, s, 32'h0, e, q);
		chk(q, exp);
	endtask
	task automatic wait_cmds(input int n);
		int k;
		k = 0;
		while (u_master.got_q.size() < n && k < 4000) begin
			@(negedge clk);
			k++;
		end
		chk({31'h0, k < 4000}, 32'h1);
	endtask
	task automatic ramp_chk(input logic [31:0] old, input logic [31:0] tgt,
			input logic [31:0] mid);
		logic [31:0] hits;
		csp_cmd_t    c;
		hits = 32'h0;
		u_master.got_q.delete();
		wr_chk(`CSP_OD_TARGET, 8'h00, tgt, 1'b0);
		wait_cmds(8);
		for (int k = 1; k < u_master.got_q.size(); k++) begin
			c = u_master.got_q[k];
			if (c.pos === mid && u_master.got_q[k-1].pos === old && c.vel_ff === 32'h7 + tgt - mid)
				hits++;
		end
		chk(hits, 32'h1);
		chk(c.pos, tgt);
		chk(c.vel_ff, 32'h7);
	endtask
	// Full run is near 2700 cycles; this leaves ample margin
	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		wrap_up();
	end
	initial begin
		bad_count = 0;
		checks_done = 0;
		rst_n = 1'b0;
		req = '0;
		mode = 1'b0;
		torque = 16'h0;
		stall = 1'b0;
		sync_en = 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		chk({24'h0, nsi}, 32'h8);
		rd_chk(`CSP_OD_TORQUE, 8'h00, 32'h0);
		rd_chk(`CSP_OD_HOME_SPEED, 8'h00, `CSP_ENTRY_COUNT);
		rd_chk(`CSP_OD_HOME_SPEED, 8'h01, 32'h0);
		rd_chk(`CSP_OD_HOME_SPEED, 8'h02, 32'h0);
		rd_chk(`CSP_OD_HOME_RAMP, 8'h00, 32'h0);
		rd_chk(`CSP_OD_SPEED_BIAS, 8'h00, 32'h0);
		rd_chk(`CSP_OD_INTERP, 8'h02, 32'hffff_fffd);
		wr_chk(`CSP_OD_HOME_SPEED, 8'h01, 32'hffff_ffff, 1'b0);
		wr_chk(`CSP_OD_HOME_SPEED, 8'h02, 32'h1234_5678, 1'b0);
		wr_chk(`CSP_OD_HOME_RAMP, 8'h00, 32'hffff_ffff, 1'b0);
		@(negedge clk);
		chk(hsw, 32'hffff_ffff);
		chk(hzero, 32'h1234_5678);
		chk(hacc, 32'hffff_ffff);
		chk(hdec, 32'hffff_ffff);
		wr_chk(`CSP_OD_TORQUE, 8'h00, 32'h5, 1'b1);
		wr_chk(`CSP_OD_HOME_SPEED, 8'h00, 32'h3, 1'b1);
		wr_chk(16'h6000, 8'h00, 32'h3, 1'b1);
		wr_chk(`CSP_OD_INTERP, 8'h02, 32'hffff_fff9, 1'b1);
		wr_chk(`CSP_OD_INTERP, 8'h02, 32'hffff_fffc, 1'b1);
		@(negedge clk);
		chk({31'h0, perr}, 32'h1);
		wr_chk(`CSP_OD_INTERP, 8'h01, 32'h5, 1'b0);
		@(negedge clk);
		chk({31'h0, perr}, 32'h0);
		wr_chk(`CSP_OD_INTERP, 8'h02, 32'hffff_fffc, 1'b0);
		// 250 x 100 us, then 250 x 1 us at the finest index, then back to 500 us
		wr_chk(`CSP_OD_INTERP, 8'h01, 32'hfa, 1'b0);
		wr_chk(`CSP_OD_INTERP, 8'h02, 32'hffff_fffa, 1'b0);
		rd_chk(`CSP_OD_INTERP, 8'h02, 32'hffff_fffa);
		wr_chk(`CSP_OD_INTERP, 8'h02, 32'hffff_fffc, 1'b0);
		wr_chk(`CSP_OD_INTERP, 8'h01, 32'h5, 1'b0);
		wr_chk(`CSP_OD_INTERP, 8'h01, 32'h7, 1'b1);
		rd_chk(`CSP_OD_INTERP, 8'h01, 32'h5);
		torque = 16'hfff0;
		repeat (2 * LOOP) @(negedge clk);
		rd_chk(`CSP_OD_TORQUE, 8'h00, 32'hffff_fff0);
		wr_chk(`CSP_OD_SPEED_BIAS, 8'h00, 32'h7, 1'b0);
		mode = 1'b1;
		repeat (4) @(negedge clk);
		chk({24'h0, nsi}, 32'h4);
		wait_cmds(6);
		ramp_chk(32'h0, 32'd1000, 32'd500);
		ramp_chk(32'd1000, 32'hffff_fc18, 32'h0);
		stall = 1'b1;
		repeat (4 * LOOP) @(negedge clk);
		chk({31'h0, cvalid}, 32'h1);
		u_master.got_q.delete();
		stall = 1'b0;
		wait_cmds(6);
		chk(u_master.got_q[0].pos, 32'hffff_fc18);
		// One command per loop period once the burst after the stall has drained
		u_master.got_q.delete();
		repeat (4 * LOOP) @(negedge clk);
		chk(u_master.got_q.size(), 32'h4);
		wr_chk(`CSP_OD_SYNC_CTRL, 8'h00, 32'h3, 1'b0);
		rd_chk(`CSP_OD_SYNC_CTRL, 8'h00, 32'h3);
		sync_en = 1'b1;
		repeat (4) @(negedge clk);
		chk({24'h0, nsi}, 32'h8);
		repeat (10 * LOOP) @(negedge clk);
		ramp_chk(32'hffff_fc18, 32'd1000, 32'h0);
		wrap_up();
	end
endmodule
